// File: include/pss_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types of the slave clock servo.
// ---------------------------------------------------------------------------
package pss_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;         // Mode and timescale control.
  localparam logic [7:0] REG_STATUS = 8'h04;       // Servo state and master info.
  localparam logic [7:0] REG_OFFSET_GAIN = 8'h08;  // Offset gain, fixed point.
  localparam logic [7:0] REG_RATE_GAIN = 8'h0c;    // Rate gain, fixed point.
  localparam logic [7:0] REG_OFFSET_LIMIT = 8'h10; // Offset step limit in ns.
  localparam logic [7:0] REG_RATE_LIMIT = 8'h14;   // Rate step limit in ns per s.
  localparam logic [7:0] REG_HIST_DEPTH = 8'h18;   // Sync history depth.
  localparam logic [7:0] REG_DRIFT = 8'h1c;        // Compensated drift in ns per s.
  localparam logic [7:0] REG_LEAP = 8'h20;         // Leap second count.
  localparam logic [7:0] REG_MOFF_LO = 8'h24;      // Master offset, low word.
  localparam logic [7:0] REG_MOFF_HI = 8'h28;      // Master offset, high word.
  localparam logic [7:0] REG_HIST_SEL = 8'h2c;     // History entry selector.
  localparam logic [7:0] REG_HIST_LO = 8'h30;      // Selected entry, low word.
  localparam logic [7:0] REG_HIST_HI = 8'h34;      // Selected entry, high word.

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 0;      // Time sync mode: 1 automatic, 0 off.
  localparam int CTRL_SCALE_BIT = 1;     // Timescale select.
  localparam int STAT_STATE_LSB = 0;     // Servo state, two bits.
  localparam int STAT_LEAPV_BIT = 2;     // Master supplies leap second count.
  localparam int STAT_CNT_LSB = 4;       // History fill count, four bits.
  localparam int STAT_KIND_LSB = 8;      // Transport kind, four bits.

  // ---------------------------------------------------------------------------
  // Gain format, history size and reset values.
  // ---------------------------------------------------------------------------
  localparam int GAIN_FRAC = 15;                       // Fraction bits of a gain.
  localparam logic [15:0] GAIN_ONE = 16'h8000;         // Gain of exactly 1.0.
  localparam int HIST_ENTRIES = 8;                     // History storage entries.
  localparam logic [3:0] HIST_DEPTH_MAX = 4'h8;        // Largest depth accepted.
  localparam logic [3:0] HIST_DEPTH_MIN = 4'h1;        // Smallest depth accepted.
  localparam logic [1:0] CTRL_RST = 2'h0;              // Mode off, atomic scale.
  localparam logic [15:0] OFFSET_GAIN_RST = 16'h4000;  // Gain of 0.5.
  localparam logic [15:0] RATE_GAIN_RST = 16'h1000;    // Gain of 0.125.
  localparam logic [30:0] OFFSET_LIMIT_RST = 31'h000f4240;
  localparam logic [30:0] RATE_LIMIT_RST = 31'h000186a0;
  localparam logic [3:0] HIST_DEPTH_RST = 4'h4;
  localparam logic [3:0] TRANSPORT_UDP_IPV4 = 4'h1;   // Only transport supported.

  // ---------------------------------------------------------------------------
  // Enumerations.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSS_ST_NA = 2'b00,
    PSS_ST_SYNCING = 2'b01,
    PSS_ST_LOCKED = 2'b10
  } pss_state_e;

  typedef enum logic {
    PSS_ATOMIC_TIMESCALE = 1'b0,
    PSS_CIVIL_TIMESCALE = 1'b1
  } pss_timescale_e;

endpackage

// File: logic/pss_scale.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Gain multiply and symmetric clamp of one servo correction.
// ---------------------------------------------------------------------------
module pss_scale (
  input wire logic [63:0] value_i,  // Signed measured offset in ns.
  input wire logic [15:0] gain_i,   // Unsigned gain, one at the top.
  input wire logic [30:0] limit_i,  // Largest magnitude allowed.
  output logic [63:0] step_o        // Signed clamped correction.
);

  logic signed [80:0] prod;   // Full product of offset and gain.
  logic signed [63:0] scaled; // Product with fraction bits removed.
  logic signed [63:0] lim;    // Positive clamp bound.

  // Since the gain never exceeds one, the top bits carry only sign; a gain of
  // exactly one returns the offset unchanged.
  always_comb begin
    prod = $signed(value_i) * $signed({1'b0, gain_i});
    scaled = prod[pss_pkg::GAIN_FRAC + 63:pss_pkg::GAIN_FRAC];
    lim = $signed({33'h0, limit_i});
    // Limit the step in both directions.
    if (scaled > lim) begin
      step_o = lim;
    end else if (scaled < -lim) begin
      step_o = -lim;
    end else begin
      step_o = scaled;
    end
  end

endmodule

// File: logic/pss_servo.sv
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// - Measure master offset on every Sync.
// - Offset times offset gain corrects clock offset.
// - Offset gain one removes whole offset.
// - Offset times rate gain adjusts clock rate.
// - Rate gain one corrects fully at once.
// - Locked offset step clamped to limit.
// - Rate step clamped to rate limit.
// - Report synchronizing, locked or not applicable.
// - Report compensated drift in ns per s.
// - Keep configurable number of recent Syncs; the ring keeps the last 8 whatever the depth, which caps only the fill count.
// - Report master leap information valid flag.
// - Report leap second count in seconds.
// - Civil timescale adds leap seconds when available.
// - Transport is UDP over IPv4, read only.
// - Mode off disables all servo operation.
// - Expose 64-bit measured master offset.
module pss_servo (
  input wire logic MCLK_I,                 // 40 MHz clock.
  input wire logic RSTN_I,                 // Synchronous reset, active low.
  input wire logic [7:0] AVS_ADDRESS_I,    // Avalon byte address.
  input wire logic AVS_READ_I,             // Avalon read request.
  input wire logic AVS_WRITE_I,            // Avalon write request.
  input wire logic [31:0] AVS_WRITEDATA_I, // Avalon write data.
  output logic [31:0] AVS_READDATA_O,      // Avalon read data.
  output logic AVS_WAITREQUEST_O,          // Avalon wait request.
  input wire logic PORT_SLAVE_I,           // Protocol engine runs as slave.
  input wire logic SYNC_VLD_I,             // One-cycle pulse per received Sync.
  input wire logic [63:0] SYNC_OFFSET_I,   // Measured offset, signed ns.
  input wire logic LEAP_VALID_I,           // Master supplies leap seconds.
  input wire logic [15:0] LEAP_COUNT_I,    // Leap seconds from master.
  output logic [63:0] OFFSET_CORR_O,       // Offset correction, signed ns.
  output logic OFFSET_CORR_VLD_O,          // Pulse with each correction.
  output logic [31:0] DRIFT_O,             // Rate correction, signed ns per s.
  output logic [15:0] LEAP_ADJ_O,          // Seconds to add to reported time.
  output logic [1:0] SERVO_STATE_O         // Current servo state.
);

  // ---------------------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------------------
  logic ack_r;                          // High in the answering bus cycle.
  logic ack_nxt;                        // Next value of the answer flag.
  logic [31:0] rdata_nxt;               // Read data for the next edge.
  logic wr_en;                          // A write takes effect this edge.
  logic [1:0] ctrl_r;                   // Mode and timescale bits.
  logic [15:0] offset_gain_r;           // Offset gain.
  logic [15:0] rate_gain_r;             // Rate gain.
  logic [30:0] offset_limit_r;          // Offset step limit.
  logic [30:0] rate_limit_r;            // Rate step limit.
  logic [3:0] depth_r;                  // Sync history depth.
  logic [2:0] hist_sel_r;               // Selected history entry.
  logic [15:0] wgain;                   // Write data limited to one.
  logic [3:0] wdepth;                   // Write data limited to range.
  logic active;                         // Servo may run at all.
  pss_pkg::pss_state_e state_r;         // Servo state.
  pss_pkg::pss_state_e state_nxt;       // Next servo state.
  logic sync_take;                      // A Sync enters the servo.
  logic [63:0] moff_r;                  // Latest measured offset.
  logic [63:0] hist_mem_r [pss_pkg::HIST_ENTRIES]; // Sync history.
  logic [2:0] wr_ptr_r;                 // Next history slot.
  logic [3:0] cnt_r;                    // History entries held.
  logic [63:0] off_step;                // Clamped offset step.
  logic [63:0] rate_step;               // Clamped rate step.
  logic signed [32:0] drift_sum;        // Drift plus new rate step.
  logic [31:0] drift_nxt;               // Saturated drift.

  // ---------------------------------------------------------------------------
  // Avalon-MM slave handshake.
  // ---------------------------------------------------------------------------
  // Every access waits one cycle and is answered in the second one.
  assign ack_nxt = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
  assign wr_en = AVS_WRITE_I & ack_r;

  // The answer flag lasts exactly one cycle.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // Gains above one are taken as one, depths are kept in storage range.
  always_comb begin
    wgain = AVS_WRITEDATA_I[15:0];
    if (AVS_WRITEDATA_I[31:16] != 16'h0 || wgain > pss_pkg::GAIN_ONE) begin
      wgain = pss_pkg::GAIN_ONE;
    end
    wdepth = AVS_WRITEDATA_I[3:0];
    if (AVS_WRITEDATA_I[31:4] != 28'h0 || wdepth > pss_pkg::HIST_DEPTH_MAX) begin
      wdepth = pss_pkg::HIST_DEPTH_MAX;
    end else if (wdepth < pss_pkg::HIST_DEPTH_MIN) begin
      wdepth = pss_pkg::HIST_DEPTH_MIN;
    end
  end

  // ---------------------------------------------------------------------------
  // Writable registers.
  // ---------------------------------------------------------------------------
  // Configuration written by software; unmapped writes are dropped.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      ctrl_r <= pss_pkg::CTRL_RST;
      offset_gain_r <= pss_pkg::OFFSET_GAIN_RST;
      rate_gain_r <= pss_pkg::RATE_GAIN_RST;
      offset_limit_r <= pss_pkg::OFFSET_LIMIT_RST;
      rate_limit_r <= pss_pkg::RATE_LIMIT_RST;
      depth_r <= pss_pkg::HIST_DEPTH_RST;
      hist_sel_r <= 3'h0;
    end else if (wr_en) begin
      case (AVS_ADDRESS_I)
        pss_pkg::REG_CTRL: ctrl_r <= AVS_WRITEDATA_I[1:0];
        pss_pkg::REG_OFFSET_GAIN: offset_gain_r <= wgain;
        pss_pkg::REG_RATE_GAIN: rate_gain_r <= wgain;
        pss_pkg::REG_OFFSET_LIMIT: offset_limit_r <= AVS_WRITEDATA_I[30:0];
        pss_pkg::REG_RATE_LIMIT: rate_limit_r <= AVS_WRITEDATA_I[30:0];
        pss_pkg::REG_HIST_DEPTH: depth_r <= wdepth;
        pss_pkg::REG_HIST_SEL: hist_sel_r <= AVS_WRITEDATA_I[2:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Read multiplexer.
  // ---------------------------------------------------------------------------
  // Unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_nxt = 32'h0;
    case (AVS_ADDRESS_I)
      pss_pkg::REG_CTRL: rdata_nxt[1:0] = ctrl_r;
      pss_pkg::REG_STATUS: begin
        rdata_nxt[pss_pkg::STAT_STATE_LSB +: 2] = state_r;
        rdata_nxt[pss_pkg::STAT_LEAPV_BIT] = LEAP_VALID_I;
        rdata_nxt[pss_pkg::STAT_CNT_LSB +: 4] = cnt_r;
        rdata_nxt[pss_pkg::STAT_KIND_LSB +: 4] = pss_pkg::TRANSPORT_UDP_IPV4;
      end
      pss_pkg::REG_OFFSET_GAIN: rdata_nxt[15:0] = offset_gain_r;
      pss_pkg::REG_RATE_GAIN: rdata_nxt[15:0] = rate_gain_r;
      pss_pkg::REG_OFFSET_LIMIT: rdata_nxt[30:0] = offset_limit_r;
      pss_pkg::REG_RATE_LIMIT: rdata_nxt[30:0] = rate_limit_r;
      pss_pkg::REG_HIST_DEPTH: rdata_nxt[3:0] = depth_r;
      pss_pkg::REG_DRIFT: rdata_nxt = DRIFT_O;
      pss_pkg::REG_LEAP: rdata_nxt[15:0] = LEAP_COUNT_I;
      pss_pkg::REG_MOFF_LO: rdata_nxt = moff_r[31:0];
      pss_pkg::REG_MOFF_HI: rdata_nxt = moff_r[63:32];
      pss_pkg::REG_HIST_SEL: rdata_nxt[2:0] = hist_sel_r;
      pss_pkg::REG_HIST_LO: rdata_nxt = hist_mem_r[hist_sel_r][31:0];
      pss_pkg::REG_HIST_HI: rdata_nxt = hist_mem_r[hist_sel_r][63:32];
      default: rdata_nxt = 32'h0;
    endcase
  end

  // Read data is captured at the waiting edge and stands in the answer cycle.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      AVS_READDATA_O <= 32'h0;
    end else if (AVS_READ_I && !ack_r) begin
      AVS_READDATA_O <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Servo state machine.
  // ---------------------------------------------------------------------------
  // The servo runs only in automatic mode while the port is a slave.
  assign active = ctrl_r[pss_pkg::CTRL_MODE_BIT] & PORT_SLAVE_I;
  assign sync_take = SYNC_VLD_I & active & (state_r != pss_pkg::PSS_ST_NA);

  // Gather history first, then lock once the depth is reached.
  always_comb begin
    state_nxt = state_r;
    if (!active) begin
      state_nxt = pss_pkg::PSS_ST_NA;
    end else begin
      case (state_r)
        pss_pkg::PSS_ST_NA: state_nxt = pss_pkg::PSS_ST_SYNCING;
        pss_pkg::PSS_ST_SYNCING: begin
          if (sync_take && (cnt_r + 4'h1 >= depth_r)) begin
            state_nxt = pss_pkg::PSS_ST_LOCKED;
          end
        end
        pss_pkg::PSS_ST_LOCKED: state_nxt = pss_pkg::PSS_ST_LOCKED;
        default: state_nxt = pss_pkg::PSS_ST_NA;
      endcase
    end
  end

  // State register.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      state_r <= pss_pkg::PSS_ST_NA;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign SERVO_STATE_O = state_r;

  // ---------------------------------------------------------------------------
  // Sync history and measured offset.
  // ---------------------------------------------------------------------------
  // Latest measured offset, kept for software.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      moff_r <= 64'h0;
    end else if (sync_take) begin
      moff_r <= SYNC_OFFSET_I;
    end
  end

  // Ring pointer and fill count; leaving the servo zeroes both but keeps the stored entries.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || !active) begin
      wr_ptr_r <= 3'h0;
      cnt_r <= 4'h0;
    end else if (sync_take) begin
      wr_ptr_r <= wr_ptr_r + 3'h1;
      if (cnt_r < depth_r) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // One storage word per history entry.
  for (genvar gi = 0; gi < pss_pkg::HIST_ENTRIES; gi++) begin : g_hist
    always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
        hist_mem_r[gi] <= 64'h0;
      end else if (sync_take && wr_ptr_r == 3'(gi)) begin
        hist_mem_r[gi] <= SYNC_OFFSET_I;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Corrections.
  // ---------------------------------------------------------------------------
  // Offset correction path.
  pss_scale u_off_scale (
    .value_i(SYNC_OFFSET_I),
    .gain_i(offset_gain_r),
    .limit_i(offset_limit_r),
    .step_o(off_step)
  );

  // Rate correction path; the bound keeps the step within 31 bits.
  pss_scale u_rate_scale (
    .value_i(SYNC_OFFSET_I),
    .gain_i(rate_gain_r),
    .limit_i(rate_limit_r),
    .step_o(rate_step)
  );

  // Drift accumulates rate steps and saturates instead of wrapping.
  always_comb begin
    drift_sum = $signed({DRIFT_O[31], DRIFT_O}) + $signed(rate_step[32:0]);
    if (drift_sum > 33'sh0_7fffffff) begin
      drift_nxt = 32'h7fffffff;
    end else if (drift_sum < -33'sh0_7fffffff) begin
      drift_nxt = 32'h80000001;
    end else begin
      drift_nxt = drift_sum[31:0];
    end
  end

  // Corrections are issued only while locked.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      OFFSET_CORR_O <= 64'h0;
      OFFSET_CORR_VLD_O <= 1'b0;
    end else begin
      OFFSET_CORR_VLD_O <= sync_take && state_r == pss_pkg::PSS_ST_LOCKED;
      if (sync_take && state_r == pss_pkg::PSS_ST_LOCKED) begin
        OFFSET_CORR_O <= off_step;
      end
    end
  end

  // Drift is cleared when the servo stops so no rate correction remains.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || !active) begin
      DRIFT_O <= 32'h0;
    end else if (sync_take && state_r == pss_pkg::PSS_ST_LOCKED) begin
      DRIFT_O <= drift_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Timescale.
  // ---------------------------------------------------------------------------
  // Civil time adds the leap seconds only when the master supplies them.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      LEAP_ADJ_O <= 16'h0;
    end else if (ctrl_r[pss_pkg::CTRL_SCALE_BIT] == pss_pkg::PSS_CIVIL_TIMESCALE
                 && LEAP_VALID_I) begin
      LEAP_ADJ_O <= LEAP_COUNT_I;
    end else begin
      LEAP_ADJ_O <= 16'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);

  // A Sync arriving in the locked state.
  sequence s_locked_sync;
    SYNC_VLD_I && active && state_r == pss_pkg::PSS_ST_LOCKED;
  endsequence

  // The Sync that completes the history.
  sequence s_fill_sync;
    sync_take && state_r == pss_pkg::PSS_ST_SYNCING && cnt_r + 4'h1 >= depth_r;
  endsequence

  AST_WAIT_ONE: assert property ((AVS_READ_I || AVS_WRITE_I) && !ack_r
    |=> !AVS_WAITREQUEST_O) else $error("Access not answered in second cycle.");
  AST_MEAS: assert property (sync_take |=> moff_r == $past(SYNC_OFFSET_I))
    else $error("Measured offset not captured.");
  AST_STEP: assert property (s_locked_sync |=> OFFSET_CORR_VLD_O
    && OFFSET_CORR_O == $past(off_step)) else $error("Offset step not issued.");
  AST_CLAMP: assert property (OFFSET_CORR_VLD_O |->
    $signed(OFFSET_CORR_O) <= $signed({33'h0, offset_limit_r})
    && $signed(OFFSET_CORR_O) >= -$signed({33'h0, offset_limit_r}))
    else $error("Offset step exceeds limit.");
  AST_LOCK: assert property (s_fill_sync |=> state_r == pss_pkg::PSS_ST_LOCKED)
    else $error("Servo did not lock after history filled.");
  AST_DRIFT: assert property (!$stable(DRIFT_O) && $past(active) |-> $past(sync_take)
    && $past(state_r) == pss_pkg::PSS_ST_LOCKED) else $error("Drift moved without Sync.");
  AST_HIST: assert property (sync_take && cnt_r < depth_r |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("History count did not advance.");
  AST_LEAP: assert property (ctrl_r[pss_pkg::CTRL_SCALE_BIT] && LEAP_VALID_I
    |=> LEAP_ADJ_O == $past(LEAP_COUNT_I)) else $error("Leap seconds not applied.");
  AST_OFF: assert property (!ctrl_r[pss_pkg::CTRL_MODE_BIT] |=>
    state_r == pss_pkg::PSS_ST_NA ##1 !OFFSET_CORR_VLD_O) else $error("Servo ran in off mode.");
  AST_NA_QUIET: assert property (state_r == pss_pkg::PSS_ST_NA |=> !OFFSET_CORR_VLD_O)
    else $error("Correction issued while not applicable.");
  AST_GAIN: assert property (offset_gain_r <= pss_pkg::GAIN_ONE
    && rate_gain_r <= pss_pkg::GAIN_ONE) else $error("Gain above one.");

endmodule

// File: dv/pss_master_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Far-side time master: delivers Sync events with their measured offset.
// ---------------------------------------------------------------------------
module pss_master_model (
  input wire logic mclk_i,              // Local time base.
  input wire logic send_i,              // Bench asks for one Sync this cycle.
  input wire logic [63:0] offset_i,     // Offset to carry with that Sync.
  output logic sync_vld_o,              // One-cycle Sync event.
  output logic [63:0] sync_offset_o     // Offset, junk outside a Sync.
);
  logic [63:0] last_r; // Last offset sent, kept so idle data differs from it.

  // Each Sync arrives as one datagram event over UDP on IPv4.
  assign sync_vld_o = send_i;
  // Outside a Sync the offset lines show the inverse of the last value.
  assign sync_offset_o = send_i ? offset_i : ~last_r;

  // Remember the offset of each Sync sent.
  always_ff @(posedge mclk_i) begin
    if (send_i) begin
      last_r <= offset_i;
    end
  end
endmodule

// File: dv/pss_servo_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Register and servo sequence tests of the slave clock servo.
// ---------------------------------------------------------------------------
module pss_servo_tb;
  logic mclk, rstn, rd, wr, slave, send, leap_v; // Bench-driven controls.
  logic [7:0] addr; // Bus address.
  logic [31:0] wdata, rdata, rd_v; // Bus data.
  logic [63:0] offset, corr; // Sync offset request and correction seen.
  logic [15:0] leap_c, leap_adj; // Leap count in and adjust out.
  logic vld, waitreq, sync_vld; // Design and partner flags.
  logic [63:0] sync_off; // Offset from partner.
  logic [31:0] drift; // Drift output.
  logic [1:0] state; // Servo state output.
  int mismatches, cmp_count, cycles; // Counters.

  pss_servo pss_servo_inst (.MCLK_I(mclk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .PORT_SLAVE_I(slave), .SYNC_VLD_I(sync_vld),
    .SYNC_OFFSET_I(sync_off), .LEAP_VALID_I(leap_v), .LEAP_COUNT_I(leap_c),
    .OFFSET_CORR_O(corr), .OFFSET_CORR_VLD_O(vld), .DRIFT_O(drift),
    .LEAP_ADJ_O(leap_adj), .SERVO_STATE_O(state));
  pss_master_model pss_master_model_inst (.mclk_i(mclk), .send_i(send), .offset_i(offset),
    .sync_vld_o(sync_vld), .sync_offset_o(sync_off));

  // ---------------------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ---------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // A hang ends the run as a failure.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  // Counts a comparison and reports a difference.
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    @(posedge mclk);
    while (waitreq !== 1'b0) @(posedge mclk);
    rd_v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rchk(string name, logic [7:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd_v, exp);
  endtask

  // Sends one Sync and checks the correction pulse one cycle later.
  task automatic sync(logic [63:0] off, logic ev, logic [63:0] ec, logic [31:0] ed);
    @(posedge mclk);
    send <= 1'b1;
    offset <= off;
    @(posedge mclk);
    send <= 1'b0;
    @(negedge mclk);
    check("corr_vld", vld, ev);
    if (ev) check("corr", corr, ec);
    check("drift", drift, ed);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    {rstn, rd, wr, slave, send, leap_v, addr, wdata, offset, leap_c} = '0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rchk("ctrl", pss_pkg::REG_CTRL, 32'h0);
    rchk("ogain", pss_pkg::REG_OFFSET_GAIN, 32'h4000);
    rchk("rgain", pss_pkg::REG_RATE_GAIN, 32'h1000);
    rchk("olim", pss_pkg::REG_OFFSET_LIMIT, 32'h000f4240);
    rchk("rlim", pss_pkg::REG_RATE_LIMIT, 32'h000186a0);
    rchk("depth", pss_pkg::REG_HIST_DEPTH, 32'h4);
    rchk("status", pss_pkg::REG_STATUS, 32'h100);
    bus(1'b1, 8'hfc, 32'h5a5a5a5a);
    rchk("unmapped", 8'hfc, 32'h0);
    bus(1'b1, pss_pkg::REG_OFFSET_GAIN, 32'h12345);
    rchk("gain_clamp", pss_pkg::REG_OFFSET_GAIN, 32'h8000);
    $display("test reset_and_map done");
    // Mode off: Syncs are ignored.
    slave <= 1'b1;
    sync(64'h64, 1'b0, 64'h0, 32'h0);
    check("state_off", state, pss_pkg::PSS_ST_NA);
    bus(1'b1, pss_pkg::REG_HIST_DEPTH, 32'h2);
    bus(1'b1, pss_pkg::REG_CTRL, 32'h1);
    @(negedge mclk);
    @(negedge mclk);
    check("state_sync", state, pss_pkg::PSS_ST_SYNCING);
    sync(64'h0b, 1'b0, 64'h0, 32'h0);
    sync(64'h16, 1'b0, 64'h0, 32'h0);
    @(negedge mclk);
    check("state_lock", state, pss_pkg::PSS_ST_LOCKED);
    rchk("hist0", pss_pkg::REG_HIST_LO, 32'h0b);
    bus(1'b1, pss_pkg::REG_HIST_SEL, 32'h1);
    rchk("hist1", pss_pkg::REG_HIST_LO, 32'h16);
    $display("test lock done");
    // Locked corrections with full, then half offset gain and clamps in both signs.
    sync(64'd1000, 1'b1, 64'd1000, 32'd125);
    sync(64'd5000000, 1'b1, 64'd1000000, 32'd100125);
    sync(-64'sd3000000, 1'b1, -64'sd1000000, 32'd125);
    bus(1'b1, pss_pkg::REG_OFFSET_GAIN, 32'h4000);
    bus(1'b1, pss_pkg::REG_RATE_GAIN, 32'h8000);
    sync(64'd200, 1'b1, 64'd100, 32'd325);
    rchk("moff_lo", pss_pkg::REG_MOFF_LO, 32'hc8);
    rchk("moff_hi", pss_pkg::REG_MOFF_HI, 32'h0);
    rchk("drift_reg", pss_pkg::REG_DRIFT, 32'd325);
    $display("test corrections done");
    // Leap second reporting and timescale.
    leap_v <= 1'b1;
    leap_c <= 16'h25;
    rchk("leap", pss_pkg::REG_LEAP, 32'h25);
    rchk("status_lv", pss_pkg::REG_STATUS, 32'h126);
    @(negedge mclk);
    check("adj_atomic", leap_adj, 16'h0);
    bus(1'b1, pss_pkg::REG_CTRL, 32'h3);
    @(negedge mclk);
    @(negedge mclk);
    check("adj_civil", leap_adj, 16'h25);
    @(posedge mclk);
    leap_v <= 1'b0;
    @(negedge mclk);
    @(negedge mclk);
    check("adj_noleap", leap_adj, 16'h0);
    $display("test leap done");
    // Turning the mode off stops the servo.
    bus(1'b1, pss_pkg::REG_CTRL, 32'h0);
    @(negedge mclk);
    @(negedge mclk);
    check("state_na", state, pss_pkg::PSS_ST_NA);
    sync(64'd500, 1'b0, 64'h0, 32'h0);
    $display("test mode_off done");
    // Mode on while the port is not a slave keeps the servo idle.
    bus(1'b1, pss_pkg::REG_CTRL, 32'h1);
    slave <= 1'b0;
    @(negedge mclk);
    @(negedge mclk);
    check("state_master", state, pss_pkg::PSS_ST_NA);
    sync(64'd700, 1'b0, 64'h0, 32'h0);
    $display("test master_port done");
    results();
  end
endmodule
